/* File: ipa_consts.svh */
`ifndef IPA_CONSTS_SVH
`define IPA_CONSTS_SVH

`define IPA_DEV_ADDR 7'h4d
`define IPA_REG_LAST 8'h09
`define IPA_REG_CNT 10
`define IPA_PTR_RD_START 8'h00
`define IPA_ACK_BIT 4'h8
`define IPA_LAST_DATA_BIT 4'h7
`define IPA_REG_RESET 8'h00

`endif

/* File: ipa_pkg.sv */
package ipa_pkg;

  typedef enum logic [2:0] {
    IPA_ST_IDLE,
    IPA_ST_ADDR,
    IPA_ST_WR,
    IPA_ST_RD,
    IPA_ST_IGNORE
  } ipa_state_t;

endpackage

/* File: ipa_regmem.sv */
`timescale 1ns/1ps
`include "ipa_consts.svh"

module ipa_regmem import ipa_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [`IPA_REG_CNT];
  logic [7:0] mem_d [`IPA_REG_CNT];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    for (int i = 0; i < `IPA_REG_CNT; i++) begin
      mem_d[i] = mem_q[i];
    end
    // reserved addresses are never stored; they read back as zero
    if (i_we && i_waddr <= `IPA_REG_LAST) begin
      mem_d[i_waddr[3:0]] = i_wdata;
    end
    rdata_d = 8'h00;
    if (i_raddr <= `IPA_REG_LAST) begin
      rdata_d = mem_q[i_raddr[3:0]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < `IPA_REG_CNT; i++) begin
        mem_q[i] <= `IPA_REG_RESET;
      end
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      for (int i = 0; i < `IPA_REG_CNT; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule // ipa_regmem

/* File: ipa_core.sv */
`timescale 1ns/1ps
`include "ipa_consts.svh"

module ipa_core import ipa_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_wr_stb,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: sample sda on each rising scl edge while i_ce is high

  logic lnk_bit_q, lnk_bit_d;

  always_comb begin
    lnk_bit_d = lnk_bit_q;
    if (i_ce) begin
      lnk_bit_d = i_sda_i;
    end
  end

  // scl only runs inside frames, so this side holds no framing state at all;
  // the edge itself is learnt from the synchronised scl, but lnk_bit_q only takes
  // its reset value if scl rises while reset is held
  always_ff @(posedge i_scl) begin
    if (!i_nrst) begin
      lnk_bit_q <= 1'b1;
    end else begin
      lnk_bit_q <= lnk_bit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and bus condition detection

  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic bit_ev, bit_v, scl_fall, start_ev, stop_ev;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else if (i_ce) begin
      {scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {i_sda_i, sda_m_q, sda_s_q};
    end
  end

  // the sampled bit is held for a whole scl period, long after the rise lands here
  assign bit_ev = scl_s_q & ~scl_p_q;
  assign bit_v = lnk_bit_q;
  assign scl_fall = scl_p_q & ~scl_s_q;
  assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  ipa_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic first_q, first_d;
  logic ack_q, ack_d;
  logic rw_q, rw_d;
  logic rep_q, rep_d;
  logic oe_q, oe_d;
  logic stb_q, stb_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic busy_q, busy_d;
  logic [7:0] byte_w;
  logic [7:0] rdata;

  assign byte_w = {sh_q[6:0], bit_v};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    first_d = first_q;
    ack_d = ack_q;
    rw_d = rw_q;
    rep_d = rep_q;
    oe_d = oe_q;
    stb_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (stop_ev) begin
      st_d = IPA_ST_IDLE;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (start_ev) begin
      // a start inside a frame is a repeated start and keeps the pointer
      rep_d = (st_q != IPA_ST_IDLE);
      st_d = IPA_ST_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      if (bit_ev) begin
        if (cnt_q != `IPA_ACK_BIT) begin
          sh_d = byte_w;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `IPA_LAST_DATA_BIT) begin
            case (st_q)
              IPA_ST_ADDR: begin
                if (byte_w[7:1] == `IPA_DEV_ADDR) begin
                  ack_d = 1'b1;
                  rw_d = byte_w[0];
                  if (byte_w[0] && !rep_q) begin
                    ptr_d = `IPA_PTR_RD_START;
                  end
                end else begin
                  st_d = IPA_ST_IGNORE;
                end
              end
              IPA_ST_WR: begin
                ack_d = 1'b1;
                if (first_q) begin
                  ptr_d = byte_w;
                  first_d = 1'b0;
                end else begin
                  // reserved addresses are strobed out but not stored
                  stb_d = 1'b1;
                  waddr_d = ptr_q;
                  wdata_d = byte_w;
                  ptr_d = ptr_q + 8'h01;
                end
              end
              default: begin
              end
            endcase
          end
        end else begin
          cnt_d = 4'h0;
          ack_d = 1'b0;
          case (st_q)
            IPA_ST_ADDR: begin
              st_d = rw_q ? IPA_ST_RD : IPA_ST_WR;
              first_d = 1'b1;
            end
            IPA_ST_RD: begin
              ptr_d = ptr_q + 8'h01;
              // a not-acknowledge ends the read; release until stop or start
              if (bit_v) begin
                st_d = IPA_ST_IGNORE;
              end
            end
            default: begin
            end
          endcase
        end
      end
      // sda only changes while scl is low, so it is settled for the next rise
      if (scl_fall) begin
        if (cnt_q == `IPA_ACK_BIT) begin
          oe_d = ack_q;
        end else if (st_q == IPA_ST_RD) begin
          oe_d = ~rdata[~cnt_q[2:0]];
        end else begin
          oe_d = 1'b0;
        end
      end
    end
    busy_d = (st_d != IPA_ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q <= IPA_ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      rep_q <= 1'b0;
      oe_q <= 1'b0;
      stb_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      first_q <= first_d;
      ack_q <= ack_d;
      rw_q <= rw_d;
      rep_q <= rep_d;
      oe_q <= oe_d;
      stb_q <= stb_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      busy_q <= busy_d;
    end
  end

  ipa_regmem u_regmem (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_we(stb_q),
    .i_waddr(waddr_q),
    .i_wdata(wdata_q),
    .i_raddr(ptr_q),
    .o_rdata(rdata)
  );

  // open drain: the pin is only ever pulled low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_wr_stb = stb_q;
  assign o_wr_addr = waddr_q;
  assign o_wr_data = wdata_q;
  assign o_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking ast_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst || !i_ce);

  AST_IGNORE_QUIET: assert property (
    (st_q == IPA_ST_IGNORE) && $past(st_q == IPA_ST_IGNORE) |-> !oe_q
  ) else $error("sda driven while frame ignored");

  AST_ACK_PHASE: assert property (
    $rose(oe_q) && (st_q != IPA_ST_RD) |-> (cnt_q == `IPA_ACK_BIT) && ack_q
  ) else $error("acknowledge driven outside ninth bit");

  AST_ADDR_ACK: assert property (
    (st_q == IPA_ST_ADDR) && bit_ev && (cnt_q == `IPA_LAST_DATA_BIT)
      && (byte_w[7:1] == `IPA_DEV_ADDR) && !start_ev && !stop_ev
      |=> ack_q && (cnt_q == `IPA_ACK_BIT)
  ) else $error("matching address not acknowledged");

  AST_PTR_LOAD: assert property (
    (st_q == IPA_ST_WR) && first_q && bit_ev && (cnt_q == `IPA_LAST_DATA_BIT)
      && !start_ev && !stop_ev |=> (ptr_q == $past(byte_w)) && !first_q
  ) else $error("pointer byte not loaded");

  AST_WR_STEP: assert property (
    stb_q |-> ##1 (ptr_q == 8'(o_wr_addr + 8'h01)) || $past(start_ev) || $past(stop_ev)
  ) else $error("pointer did not step after write");

  AST_RD_ZERO: assert property (
    (st_q == IPA_ST_ADDR) && !rep_q && bit_ev && (cnt_q == `IPA_LAST_DATA_BIT)
      && (byte_w == {`IPA_DEV_ADDR, 1'b1}) && !start_ev && !stop_ev
      |=> (ptr_q == `IPA_PTR_RD_START) && rw_q
  ) else $error("plain read did not start at register zero");

  AST_RD_STEP: assert property (
    (st_q == IPA_ST_RD) && bit_ev && (cnt_q == `IPA_ACK_BIT) && !start_ev && !stop_ev
      |=> ptr_q == 8'($past(ptr_q) + 8'h01)
  ) else $error("pointer did not step after read byte");

  AST_RD_BIT: assert property (
    $fell(scl_s_q) && (st_q == IPA_ST_RD) && (cnt_q < `IPA_ACK_BIT)
      && !start_ev && !stop_ev |=> (oe_q == ~rdata[~cnt_q[2:0]]) [*2]
  ) else $error("read bit not presented");

  AST_STOP_IDLE: assert property (
    stop_ev |=> (st_q == IPA_ST_IDLE) && !oe_q ##1 !busy_q
  ) else $error("stop not recognised");

endmodule // ipa_core

/* File: ipa_i2c_master.sv */
`timescale 1ns/1ps
module ipa_i2c_master (
  input wire logic i_tick,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one tick a phase: scl low and high both last two ticks, sda moves only with scl low except in start and stop
  task automatic send_bit(input logic b);
    @(posedge i_tick) o_sda_oe = ~b;
    @(posedge i_tick) o_scl = 1'b1;
    @(posedge i_tick);
    @(posedge i_tick) o_scl = 1'b0;
  endtask
  task automatic take_bit(output logic b);
    logic s1;
    @(posedge i_tick) o_sda_oe = 1'b0;
    @(posedge i_tick) o_scl = 1'b1;
    @(posedge i_tick) s1 = i_sda;
    @(posedge i_tick);
    // a level that moves inside the high phase is reported unknown
    b = (s1 === i_sda) ? s1 : 1'bx;
    o_scl = 1'b0;
  endtask
  task automatic start_cond();
    @(posedge i_tick) o_sda_oe = 1'b0;
    @(posedge i_tick) o_scl = 1'b1;
    @(posedge i_tick) o_sda_oe = 1'b1;
    @(posedge i_tick) o_scl = 1'b0;
  endtask
  task automatic stop_cond();
    @(posedge i_tick) o_sda_oe = 1'b1;
    @(posedge i_tick) o_scl = 1'b1;
    @(posedge i_tick) o_sda_oe = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    take_bit(ack);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      take_bit(b);
      d[i] = b;
    end
    send_bit(last);
  endtask
endmodule // ipa_i2c_master

/* File: i2c_register_pointer_access_bench.sv */
`timescale 1ns/1ps
module i2c_register_pointer_access_bench;
  logic i_clk = 1'b0;
  logic tick = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic scl, sda, m_oe, o_sda_o, o_sda_oe, o_wr_stb, o_busy;
  logic [7:0] o_wr_addr, o_wr_data, stb_addr, stb_data;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int stb_cnt = 0;
  always #5 i_clk = ~i_clk;
  // link clock offset so its edges never line up with i_clk
  always begin
    #37;
    tick = ~tick;
    #3;
  end
  assign sda = (o_sda_oe ? o_sda_o : 1'b1) & ~m_oe;
  ipa_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_scl(scl), .i_sda_i(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wr_stb(o_wr_stb), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .o_busy(o_busy));
  ipa_i2c_master master (.i_tick(tick), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  always @(negedge i_clk) begin
    if (o_wr_stb === 1'b1) begin
      stb_cnt++;
      stb_addr = o_wr_addr;
      stb_data = o_wr_data;
    end
    cycles++;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, output logic [7:0] ack);
    logic a;
    master.put_byte(d, a);
    ack = {7'h00, a};
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] a;
    int n;
    n = stb_cnt;
    master.start_cond();
    send(8'h9a, a);
    check(a, 8'h00, "write address ack");
    send(ptr, a);
    check(a, 8'h00, "pointer ack");
    send(d0, a);
    check(a, 8'h00, "data ack");
    check(stb_addr, ptr, "store address");
    check(stb_data, d0, "store data");
    send(d1, a);
    check(stb_addr, ptr + 8'h01, "next store address");
    check(stb_data, d1, "next store data");
    check(8'(stb_cnt - n), 8'h02, "store count");
    master.stop_cond();
  endtask
  task automatic read_frame(input logic rs, input logic [7:0] ptr, input logic [7:0] e0,
                            input logic [7:0] e1);
    logic [7:0] a;
    logic [7:0] d;
    master.start_cond();
    if (rs) begin
      send(8'h9a, a);
      send(ptr, a);
      master.start_cond();
    end
    send(8'h9b, a);
    check(a, 8'h00, "read address ack");
    master.get_byte(1'b0, d);
    check(d, e0, "first read byte");
    master.get_byte(1'b1, d);
    check(d, e1, "second read byte");
    master.stop_cond();
  endtask
  task automatic foreign_address();
    logic [7:0] a;
    logic [7:0] addrs [3] = '{8'h98, 8'h1b, 8'hda};
    int n;
    n = stb_cnt;
    foreach (addrs[i]) begin
      master.start_cond();
      send(addrs[i], a);
      check(a, 8'h01, "foreign address ack");
      send(8'h03, a);
      check(a, 8'h01, "ignored byte ack");
      master.stop_cond();
    end
    check(8'(stb_cnt - n), 8'h00, "foreign stores");
  endtask
  task automatic early_stop();
    logic [7:0] a;
    int n;
    n = stb_cnt;
    master.start_cond();
    send(8'h9a, a);
    check({7'h00, o_busy}, 8'h01, "busy in frame");
    send(8'h02, a);
    for (int i = 0; i < 4; i++) master.send_bit(1'b1);
    master.stop_cond();
    for (int i = 0; i < 20 && o_busy !== 1'b0; i++) @(negedge i_clk);
    check({7'h00, o_busy}, 8'h00, "idle after stop");
    check(8'(stb_cnt - n), 8'h00, "partial byte stores");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    check({5'h00, o_sda_oe, o_wr_stb, o_busy}, 8'h00, "reset outputs");
    repeat (10) @(negedge i_clk);
    write_regs(8'h00, 8'h3c, 8'h5a);
    // the second write lands on the last register; reading past it returns zero
    write_regs(8'h08, 8'h77, 8'h88);
    write_regs(8'h04, 8'hc3, 8'h18);
    read_frame(1'b0, 8'h00, 8'h3c, 8'h5a);
    read_frame(1'b1, 8'h09, 8'h88, 8'h00);
    read_frame(1'b0, 8'h00, 8'h3c, 8'h5a);
    read_frame(1'b1, 8'h04, 8'hc3, 8'h18);
    foreign_address();
    early_stop();
    write_regs(8'h01, 8'ha5, 8'h96);
    read_frame(1'b0, 8'h00, 8'h3c, 8'ha5);
    complete_run();
  end
endmodule // i2c_register_pointer_access_bench
